// ### common/efs_pers_if.sv
// persistence timer hookup: frame tick, raw condition, filtered alarm
`timescale 1ns/1ps
interface efs_pers_if;
    logic tick;
    logic cond;
    logic alarm;
    modport core (input tick, input cond, output alarm);
    modport user (output tick, output cond, input alarm);
endinterface

// ### common/efs_pkg.sv
// shared constants for the e1 framer status readout
// Behaviour
// - line alarm sets after 100 ms of all-ones while out of frame, clears after 100 ms
// - spare capture: bit 7 alignment international bit, bits 6..0 non-alignment bits
// - spare capture refreshed after slot 0 of each non-alignment frame, valid two frames
// - a read latches the spare capture; bits may come from different frames
// - non-alignment byte: international, fixed one, remote alarm, national 0..4
// - slot 16 positions 5..8 of multiframe frame 0 go to register bits 3..0
// - extra-bit capture updated once per signaling multiframe, valid one multiframe
// - crc errors counted to 10 bits, moved each second: low byte, then bits 9..8
// - fresh flag set on count transfer, cleared by reading the upper count register
// - overwritten flag set when a transfer beats the read, cleared by upper read
// - the one-second crc interval is timed internally, never by outside requests
// - slot 16 detect event: two all-ones slot 16 bytes while multiframe is lost
// - interval counter up with event, down without; alarm at 22, removed at 0
// - slot 16 change flag set on each alarm toggle, cleared when its register is read
// - with the enable set, every slot 16 alarm change raises the interrupt
// - slot 16 alarm follows about 3 ms of all-ones presence and absence
// - four channel copies of each register, spaced 080H apart from the first
// - frame-lost input is true while basic alignment is lost
// - multiframe-lost input is true while signaling multiframe alignment is lost
package efs_pkg;
    localparam int NUM_CH = 4;
    localparam int CH_LSB = 7;
    localparam logic [6:0] OFS_SPARE = 7'h28;
    localparam logic [6:0] OFS_EXTRA = 7'h29;
    localparam logic [6:0] OFS_CNT_LO = 7'h2A;
    localparam logic [6:0] OFS_CNT_HI = 7'h2B;
    localparam logic [6:0] OFS_S16 = 7'h2C;
    localparam int FRAME_NS = 125000;
    localparam int SECOND_MS = 1000;
    localparam int LINE_ALARM_MS = 100;
    localparam int FRAMES_PER_SEC = SECOND_MS * 1000000 / FRAME_NS;
    localparam int LINE_ALARM_FRAMES = LINE_ALARM_MS * 1000000 / FRAME_NS;
    localparam int S16_DECLARE = 22;
    localparam int CNT_W = 10;
    localparam int NA_INTL_BIT = 7;
    localparam int NA_RA_BIT = 5;
    localparam int CNT_OVR_BIT = 7;
    localparam int CNT_FRESH_BIT = 6;
    localparam int S16_EN_BIT = 6;
    localparam int S16_CHG_BIT = 5;
    localparam int S16_ALARM_BIT = 4;
    localparam logic S16_EN_RST = 1'b0;
    localparam logic FLAG_RST = 1'b0;
    localparam logic [7:0] ALL_ONES = 8'hFF;
endpackage

// ### hw/efs_persist.sv
// persistence filter: alarm follows a condition held for a number of frames
`timescale 1ns/1ps
module efs_persist #(
    parameter int FRAMES = efs_pkg::LINE_ALARM_FRAMES
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    efs_pers_if.core pif
);
    import efs_pkg::*;

    localparam int W = $clog2(FRAMES + 1);

    logic [W-1:0] cnt_r;
    logic alarm_r;

    initial begin
        if (FRAMES < 1) begin
            $error("efs_persist: FRAMES must be at least 1");
        end
    end

    // count consecutive frames that disagree with the present alarm state
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
            alarm_r <= 1'b0;
        end else if (pif.tick) begin
            if (pif.cond == alarm_r) begin
                cnt_r <= '0;
            end else if (cnt_r == W'(FRAMES - 1)) begin
                cnt_r <= '0;
                alarm_r <= pif.cond;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign pif.alarm = alarm_r;
endmodule

// ### hw/efs_status_top.sv
// receive framer status readout for four e1 channels
`timescale 1ns/1ps
module efs_status_top #(
    parameter int NCH = efs_pkg::NUM_CH,
    parameter int FRAMES_PER_SEC = efs_pkg::FRAMES_PER_SEC,
    parameter int LINE_ALARM_FRAMES = efs_pkg::LINE_ALARM_FRAMES
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [NCH-1:0] i_frame_strobe,
    input wire logic [NCH-1:0] i_ts0_strobe,
    input wire logic [NCH-1:0] i_ts16_strobe,
    input wire logic [NCH-1:0][7:0] i_slot_byte,
    input wire logic [NCH-1:0] i_alignment_frame,
    input wire logic [NCH-1:0] i_mf_frame0,
    input wire logic [NCH-1:0] i_frame_lost,
    input wire logic [NCH-1:0] i_mf_lost,
    input wire logic [NCH-1:0] i_line_ones,
    input wire logic [NCH-1:0] i_crc_err,
    input wire logic [8:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic [NCH-1:0] o_line_alarm,
    output logic [NCH-1:0] o_slot16_alarm,
    output logic [NCH-1:0] o_slot16_irq
);
    import efs_pkg::*;

    localparam int SW = $clog2(FRAMES_PER_SEC + 1);
    localparam int IW = $clog2(S16_DECLARE + 1);

    initial begin
        if (NCH < 1 || NCH > 4) begin
            $error("efs_status_top: NCH must be 1 to 4");
        end
        if (FRAMES_PER_SEC < 2) begin
            $error("efs_status_top: FRAMES_PER_SEC must be at least 2");
        end
        if (LINE_ALARM_FRAMES < 1) begin
            $error("efs_status_top: LINE_ALARM_FRAMES must be at least 1");
        end
    end

    // register decode
    logic [1:0] sel_ch;
    logic [6:0] sel_ofs;
    logic ch_ok;
    logic [NCH-1:0] rd_cnt_hi;
    logic [NCH-1:0] rd_s16;
    logic [NCH-1:0] wr_s16;

    assign sel_ch = i_addr[8:CH_LSB];
    assign sel_ofs = i_addr[CH_LSB-1:0];
    assign ch_ok = (32'(sel_ch) < NCH);
    // channels at or above NCH decode to nothing, so they read as zero

    // each channel owns a 080H window, same offsets inside
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            rd_cnt_hi[c] = i_rd && ch_ok && (sel_ch == 2'(c)) && (sel_ofs == OFS_CNT_HI);
            rd_s16[c] = i_rd && ch_ok && (sel_ch == 2'(c)) && (sel_ofs == OFS_S16);
            wr_s16[c] = i_wr && ch_ok && (sel_ch == 2'(c)) && (sel_ofs == OFS_S16);
        end
    end

    // spare bit capture
    // the alignment international bit waits here for the next non-alignment frame
    logic [NCH-1:0] align_intl_r;
    logic [7:0] spare_r [NCH];

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            align_intl_r <= '0;
            for (int c = 0; c < NCH; c++) begin
                spare_r[c] <= 8'h00;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (i_ts0_strobe[c] && i_alignment_frame[c]) begin
                    align_intl_r[c] <= i_slot_byte[c][NA_INTL_BIT];
                end
                // non-alignment byte msb first: intl, fixed one, remote alarm, national 0..4
                if (i_ts0_strobe[c] && !i_alignment_frame[c]) begin
                    spare_r[c] <= {align_intl_r[c],
                                   i_slot_byte[c][NA_INTL_BIT],
                                   i_slot_byte[c][NA_RA_BIT],
                                   i_slot_byte[c][4:0]};
                end
            end
        end
    end

    // extra bits and remote multiframe alarm from slot 16 of multiframe frame 0
    // bit 3 extra 3, bit 2 remote multiframe alarm, bits 1..0 extra 1 and 0
    logic [3:0] extra_r [NCH];

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            for (int c = 0; c < NCH; c++) begin
                extra_r[c] <= 4'h0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (i_ts16_strobe[c] && i_mf_frame0[c]) begin
                    extra_r[c] <= i_slot_byte[c][3:0];
                end
            end
        end
    end

    // one-second timebase from received frames, never from outside requests
    logic [SW-1:0] sec_cnt_r [NCH];
    logic [NCH-1:0] sec_end;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            sec_end[c] = i_frame_strobe[c] && (sec_cnt_r[c] == SW'(FRAMES_PER_SEC - 1));
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            for (int c = 0; c < NCH; c++) begin
                sec_cnt_r[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (sec_end[c]) begin
                    sec_cnt_r[c] <= '0;
                end else if (i_frame_strobe[c]) begin
                    sec_cnt_r[c] <= sec_cnt_r[c] + 1'b1;
                end
            end
        end
    end

    // crc error accumulator, saturating at the top of its range
    logic [CNT_W-1:0] crc_acc_r [NCH];
    logic [CNT_W-1:0] crc_hold_r [NCH];

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            for (int c = 0; c < NCH; c++) begin
                crc_acc_r[c] <= '0;
                crc_hold_r[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (sec_end[c]) begin
                    crc_hold_r[c] <= crc_acc_r[c];
                    // an error on the boundary cycle belongs to the new second
                    crc_acc_r[c] <= CNT_W'(i_crc_err[c]);
                end else if (i_crc_err[c] && (crc_acc_r[c] != '1)) begin
                    crc_acc_r[c] <= crc_acc_r[c] + 1'b1;
                end
            end
        end
    end

    // fresh and overwritten flags: a transfer wins over a clearing read for the fresh flag, the read wins for the overwritten flag
    logic [NCH-1:0] fresh_r;
    logic [NCH-1:0] ovr_r;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            fresh_r <= {NCH{FLAG_RST}};
            ovr_r <= {NCH{FLAG_RST}};
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (sec_end[c]) begin
                    fresh_r[c] <= 1'b1;
                    // a read in the transfer cycle returned the old flags, so it still clears
                    ovr_r[c] <= ~rd_cnt_hi[c] & (ovr_r[c] | fresh_r[c]);
                end else if (rd_cnt_hi[c]) begin
                    fresh_r[c] <= 1'b0;
                    ovr_r[c] <= 1'b0;
                end
            end
        end
    end

    // slot 16 all-ones detection while multiframe alignment is lost
    logic [NCH-1:0] s16_prev_ones_r;
    logic [NCH-1:0] s16_event_r;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            s16_prev_ones_r <= '0;
            s16_event_r <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (i_ts16_strobe[c]) begin
                    s16_prev_ones_r[c] <= (i_slot_byte[c] == ALL_ONES);
                end
                // one event flag per frame; the frame strobe opens a fresh interval
                if (i_frame_strobe[c]) begin
                    s16_event_r[c] <= 1'b0;
                end else if (i_ts16_strobe[c] && i_mf_lost[c] && s16_prev_ones_r[c]
                             && (i_slot_byte[c] == ALL_ONES)) begin
                    s16_event_r[c] <= 1'b1;
                end
            end
        end
    end

    // interval integrator: one interval per received frame
    // declare on the step into the top count, remove on the step down to zero
    logic [IW-1:0] s16_cnt_r [NCH];
    logic [NCH-1:0] s16_alarm_r;
    logic [NCH-1:0] s16_alarm_nxt;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            s16_alarm_nxt[c] = s16_alarm_r[c];
            if (i_frame_strobe[c]) begin
                if (s16_event_r[c] && s16_cnt_r[c] == IW'(S16_DECLARE - 1)) begin
                    s16_alarm_nxt[c] = 1'b1;
                end else if (!s16_event_r[c] && s16_cnt_r[c] == IW'(1)) begin
                    s16_alarm_nxt[c] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            s16_alarm_r <= '0;
            for (int c = 0; c < NCH; c++) begin
                s16_cnt_r[c] <= '0;
            end
        end else begin
            s16_alarm_r <= s16_alarm_nxt;
            for (int c = 0; c < NCH; c++) begin
                if (i_frame_strobe[c]) begin
                    if (s16_event_r[c] && s16_cnt_r[c] != IW'(S16_DECLARE)) begin
                        s16_cnt_r[c] <= s16_cnt_r[c] + 1'b1;
                    end else if (!s16_event_r[c] && s16_cnt_r[c] != '0) begin
                        s16_cnt_r[c] <= s16_cnt_r[c] - 1'b1;
                    end
                end
            end
        end
    end

    // change flag and interrupt enable; a toggle wins over a clearing read
    logic [NCH-1:0] s16_chg_r;
    logic [NCH-1:0] s16_en_r;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            s16_chg_r <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (s16_alarm_nxt[c] != s16_alarm_r[c]) begin
                    s16_chg_r[c] <= 1'b1;
                end else if (rd_s16[c]) begin
                    s16_chg_r[c] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            s16_en_r <= {NCH{S16_EN_RST}};
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (wr_s16[c]) begin
                    s16_en_r[c] <= i_wdata[S16_EN_BIT];
                end
            end
        end
    end

    assign o_slot16_irq = s16_chg_r & s16_en_r;
    assign o_slot16_alarm = s16_alarm_r;

    // line alarm: all-ones while out of frame, filtered over 100 ms of frames
    for (genvar g = 0; g < NCH; g++) begin : g_line
        efs_pers_if pif ();
        // the filter looks at the condition only at frame strobes
        assign pif.tick = i_frame_strobe[g];
        assign pif.cond = i_frame_lost[g] & i_line_ones[g];
        assign o_line_alarm[g] = pif.alarm;
        efs_persist #(
            .FRAMES(LINE_ALARM_FRAMES)
        ) u_line (
            .i_mclk(i_mclk),
            .i_rst_n(i_rst_n),
            .pif(pif.core)
        );
    end

    // read mux, sampled at the read strobe and held for the following cycle
    logic [7:0] rd_mux;
    // unused bits and unmapped offsets read as zero
    int ci;

    always_comb begin
        rd_mux = 8'h00;
        ci = 32'(sel_ch);
        if (ch_ok) begin
            case (sel_ofs)
                OFS_SPARE: begin
                    rd_mux = spare_r[ci];
                end
                OFS_EXTRA: begin
                    rd_mux = {4'h0, extra_r[ci]};
                end
                OFS_CNT_LO: begin
                    rd_mux = crc_hold_r[ci][7:0];
                end
                OFS_CNT_HI: begin
                    rd_mux = 8'h00;
                    rd_mux[CNT_OVR_BIT] = ovr_r[ci];
                    rd_mux[CNT_FRESH_BIT] = fresh_r[ci];
                    rd_mux[1:0] = crc_hold_r[ci][CNT_W-1:8];
                end
                OFS_S16: begin
                    rd_mux = 8'h00;
                    rd_mux[S16_EN_BIT] = s16_en_r[ci];
                    rd_mux[S16_CHG_BIT] = s16_chg_r[ci];
                    rd_mux[S16_ALARM_BIT] = s16_alarm_r[ci];
                end
                default: begin
                    rd_mux = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            // sampled at the read edge, so the answer cannot change while it stands
            o_rdata <= rd_mux;
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule

// ### sim/efs_line_model.sv
// line stream model: 16-cycle frames, slot 0 and slot 16 bytes, 16-frame multiframe
`timescale 1ns/1ps
module efs_line_model #(
    parameter int NCH = 4
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_fas_b,
    input wire logic [7:0] i_non_alignment_frame_b,
    input wire logic [7:0] i_mf0_b,
    input wire logic [7:0] i_t16_b,
    output logic [NCH-1:0] o_fstb,
    output logic [NCH-1:0] o_t0s,
    output logic [NCH-1:0] o_t16s,
    output logic [NCH-1:0][7:0] o_byte,
    output logic [NCH-1:0] o_alg,
    output logic [NCH-1:0] o_mf0
);
    logic [3:0] cyc_r, frm_r;
    logic [7:0] byte_r;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cyc_r <= 4'h0;
            frm_r <= 4'h0;
            byte_r <= 8'h00;
        end else begin
            cyc_r <= cyc_r + 4'h1;
            if (cyc_r == 4'hF) frm_r <= frm_r + 4'h1;
            // odd frames carry the non-alignment byte
            if (cyc_r == 4'h2) byte_r <= frm_r[0] ? i_non_alignment_frame_b : i_fas_b;
            else if (cyc_r == 4'h6) byte_r <= (frm_r == 4'h0) ? i_mf0_b : i_t16_b;
            else byte_r <= ~byte_r; // no stale byte between slots
        end
    end
    assign o_fstb = {NCH{cyc_r == 4'hF}};
    assign o_t0s = {NCH{cyc_r == 4'h3}};
    assign o_t16s = {NCH{cyc_r == 4'h7}};
    assign o_byte = {NCH{byte_r}};
    assign o_alg = {NCH{!frm_r[0]}};
    assign o_mf0 = {NCH{frm_r == 4'h0}};
endmodule

// ### sim/efs_status_chk.sv
// port assertions for the e1 framer status readout
`timescale 1ns/1ps
module efs_status_chk import efs_pkg::*; #(
    parameter int NCH = 4
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [NCH-1:0] i_frame_strobe,
    input wire logic [NCH-1:0] i_frame_lost,
    input wire logic [NCH-1:0] i_line_ones,
    input wire logic [8:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic [NCH-1:0] o_line_alarm,
    input wire logic [NCH-1:0] o_slot16_alarm,
    input wire logic [NCH-1:0] o_slot16_irq
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    property p_rd_idle;
        !$past(i_rd) |-> o_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_rsv;
        i_rd && (i_addr[6:0] < OFS_SPARE || i_addr[6:0] > OFS_S16) |=> o_rdata == 8'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved offset not zero");
    property p_hi_clr;
        i_rd && i_addr[6:0] == OFS_CNT_HI && i_frame_strobe == '0 ##1
        i_rd && $stable(i_addr) && i_frame_strobe == '0 |=> o_rdata[7:6] == 2'h0;
    endproperty
    a_hi_clr: assert property (p_hi_clr) else $error("count flags survive read");
    property p_line_step;
        ((o_line_alarm ^ $past(o_line_alarm)) & ~$past(i_frame_strobe)) == '0;
    endproperty
    a_line_step: assert property (p_line_step) else $error("line alarm off tick");
    property p_line_rise;
        ((o_line_alarm & ~$past(o_line_alarm)) & ~$past(i_frame_lost & i_line_ones)) == '0;
    endproperty
    a_line_rise: assert property (p_line_rise) else $error("line alarm rose");
    property p_line_fall;
        ((~o_line_alarm & $past(o_line_alarm)) & $past(i_frame_lost & i_line_ones)) == '0;
    endproperty
    a_line_fall: assert property (p_line_fall) else $error("line alarm fell");
    property p_s16_step;
        ((o_slot16_alarm ^ $past(o_slot16_alarm)) & ~$past(i_frame_strobe)) == '0;
    endproperty
    a_s16_step: assert property (p_s16_step) else $error("slot16 alarm off tick");
    property p_irq_rise;
        !$past(i_wr) |->
        ((o_slot16_irq & ~$past(o_slot16_irq)) & ~(o_slot16_alarm ^ $past(o_slot16_alarm))) == '0;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq without change");
    property p_irq_fall;
        (~o_slot16_irq & $past(o_slot16_irq)) != '0 |-> $past(i_rd || i_wr);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell unasked");
    c_line: cover property ($rose(o_line_alarm[3]));
    c_irq: cover property ($rose(o_slot16_irq[0]));
    c_hi2: cover property (i_rd && i_addr[6:0] == OFS_CNT_HI ##1 i_rd);
endmodule
bind efs_status_top efs_status_chk #(.NCH(NCH)) chk_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_frame_strobe(i_frame_strobe), .i_frame_lost(i_frame_lost), .i_line_ones(i_line_ones),
    .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_line_alarm(o_line_alarm),
    .o_slot16_alarm(o_slot16_alarm), .o_slot16_irq(o_slot16_irq));

// ### sim/testbench.sv
// self-checking bench for the e1 framer status readout
`timescale 1ns/1ps
module testbench;
    import efs_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [3:0] fstb, t0s, t16s, alg, mf0, o_line_alarm, o_slot16_alarm, o_slot16_irq;
    logic [3:0] i_frame_lost, i_mf_lost, i_line_ones, i_crc_err;
    logic [3:0][7:0] sbyte;
    logic [8:0] i_addr;
    logic [7:0] i_wdata, o_rdata, fas_b, non_alignment_frame_b, mf0_b, t16_b;
    logic i_wr, i_rd;
    int mismatches = 0;
    int check_count = 0;
    always #50 i_mclk = ~i_mclk;
    efs_line_model line_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_fas_b(fas_b),
        .i_non_alignment_frame_b(non_alignment_frame_b), .i_mf0_b(mf0_b), .i_t16_b(t16_b), .o_fstb(fstb), .o_t0s(t0s),
        .o_t16s(t16s), .o_byte(sbyte), .o_alg(alg), .o_mf0(mf0));
    efs_status_top #(.FRAMES_PER_SEC(64), .LINE_ALARM_FRAMES(4)) dut_u (.i_mclk(i_mclk),
        .i_rst_n(i_rst_n), .i_frame_strobe(fstb), .i_ts0_strobe(t0s), .i_ts16_strobe(t16s),
        .i_slot_byte(sbyte), .i_alignment_frame(alg), .i_mf_frame0(mf0),
        .i_frame_lost(i_frame_lost), .i_mf_lost(i_mf_lost), .i_line_ones(i_line_ones),
        .i_crc_err(i_crc_err), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_line_alarm(o_line_alarm), .o_slot16_alarm(o_slot16_alarm),
        .o_slot16_irq(o_slot16_irq));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(posedge i_mclk);
        d = o_rdata;
    endtask
    task automatic chk(input logic [8:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        cmp({8'h00, d}, {8'h00, e});
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic frames(input int n);
        repeat (n) begin
            @(posedge i_mclk);
            while (fstb[0] !== 1'b1) @(posedge i_mclk);
        end
    endtask
    // frames until the watched alarm reaches lvl (sel 0: line ch3, 1: slot16 ch0)
    task automatic count_to(input int sel, input logic lvl, output int n);
        n = 0;
        do begin
            frames(1);
            n++;
            @(posedge i_mclk);
        end while (((sel == 0) ? o_line_alarm[3] : o_slot16_alarm[0]) !== lvl && n < 40);
    endtask
    task automatic poll_fresh(output logic [7:0] d);
        int k;
        k = 0;
        do begin
            rd(9'h0AB, d);
            k++;
        end while (d[6] !== 1'b1 && k < 1200);
    endtask
    task automatic t_regs();
        chk(9'h02B, 8'h00);
        chk(9'h02C, 8'h00);
        chk(9'h030, 8'h00);
        wr(9'h02C, 8'hFF);
        chk(9'h02C, 8'h40);
        $display("regs done");
    endtask
    task automatic t_spare();
        fas_b <= 8'h9B;
        non_alignment_frame_b <= 8'h25;
        frames(4);
        chk(9'h128, 8'hA5);
        fas_b <= 8'h1B;
        non_alignment_frame_b <= 8'hDA;
        frames(3);
        chk(9'h1A8, 8'h5A);
        $display("spare done");
    endtask
    task automatic t_extra();
        mf0_b <= 8'hF6;
        t16_b <= 8'h09;
        frames(17);
        chk(9'h0A9, 8'h06);
        mf0_b <= 8'h0B;
        frames(17);
        chk(9'h0A9, 8'h0B);
        $display("extra done");
    endtask
    task automatic t_crc();
        logic [7:0] d, d2;
        poll_fresh(d);
        repeat (300) begin
            i_crc_err <= 4'h2;
            @(posedge i_mclk);
            i_crc_err <= 4'h0;
            @(posedge i_mclk);
        end
        poll_fresh(d);
        cmp({8'h00, d}, 16'h0041);
        chk(9'h0AA, 8'h2C);
        chk(9'h02A, 8'h00);
        repeat (2200) @(posedge i_mclk);
        i_addr <= 9'h0AB;
        i_rd <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_rd <= 1'b0;
        d = o_rdata;
        @(posedge i_mclk);
        d2 = o_rdata;
        cmp({8'h00, d}, 16'h00C0);
        cmp({8'h00, d2}, 16'h0000);
        $display("crc done");
    endtask
    task automatic t_s16();
        int n;
        t16_b <= 8'h00;
        mf0_b <= 8'h00;
        i_mf_lost <= 4'hB;
        frames(2);
        t16_b <= 8'hFF;
        mf0_b <= 8'hFF;
        count_to(1, 1'b1, n);
        t16_b <= 8'h00;
        mf0_b <= 8'h00;
        cmp(16'(n), 16'h0017);
        cmp({12'h000, o_slot16_alarm}, 16'h000B);
        cmp({12'h000, o_slot16_irq}, 16'h0001);
        chk(9'h02C, 8'h70);
        cmp({12'h000, o_slot16_irq}, 16'h0000);
        chk(9'h02C, 8'h50);
        count_to(1, 1'b0, n);
        cmp(16'(n), 16'h0016);
        chk(9'h02C, 8'h60);
        i_mf_lost <= 4'h0;
        $display("slot16 done");
    endtask
    task automatic t_line();
        int n;
        frames(1);
        i_line_ones <= 4'hC;
        i_frame_lost <= 4'h9;
        count_to(0, 1'b1, n);
        cmp(16'(n), 16'h0004);
        cmp({12'h000, o_line_alarm}, 16'h0008);
        i_frame_lost <= 4'h0;
        count_to(0, 1'b0, n);
        cmp(16'(n), 16'h0004);
        $display("line done");
    endtask
    initial begin
        {i_frame_lost, i_mf_lost, i_line_ones, i_crc_err} = '0;
        {i_wr, i_rd, i_addr, i_wdata} = '0;
        {fas_b, non_alignment_frame_b, mf0_b, t16_b} = '0;
        repeat (12) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        t_regs();
        t_spare();
        t_extra();
        t_crc();
        t_s16();
        t_line();
        finish_test();
    end
    initial begin
        #2000000;
        mismatches++;
        finish_test();
    end
endmodule
